// [hdl/mbsrv_top.sv]
// Modbus server: query checking, coil and input map, error logging
`timescale 1ns/100ps
module mbsrv_top
   import mbsrv_pkg::*;
(
   input  wire logic        sys_clk,
   input  wire logic        rst_n,
   input  wire logic        altProfile,
   input  wire logic        qryValid,
   input  wire logic [7:0]  qryFunc,
   input  wire logic [15:0] qryAddr,
   input  wire logic [15:0] qryQty,
   input  wire logic [15:0] qryWrBits,
   input  wire logic [15:0] qryWrWord,
   input  wire logic [31:0] statusWord,
   input  wire logic [5:0]  diDelayed,
   output logic             qryReady,
   output logic             rspValid,
   output logic             rspExc,
   output logic      [7:0]  rspCode,
   output logic      [15:0] rspData,
   output logic      [31:0] ctrlWord,
   output logic      [4:0]  relayCtrl
);
   localparam int COIL_W = CTL_BITS + RELAY_BITS;
   localparam int DIN_W  = CTL_BITS + DI_BITS;

   mbsrv_state_t state_r;
   mbsrv_state_t state_nxt;

   logic             qryReady_r;
   logic             rspValid_r;
   logic             rspExc_r;
   logic [7:0]       rspCode_r;
   logic [15:0]      rspData_r;
   logic [31:0]      ctrlWord_r;
   logic [4:0]       relayCtrl_r;

   logic [7:0]       func_r;
   logic [15:0]      addr_r;
   logic [15:0]      qty_r;
   logic [15:0]      wrBits_r;
   logic [15:0]      wrWord_r;
   logic             prof_r;
   logic [7:0]       exc_r;
   logic [7:0]       cause_r;
   logic [7:0]       exc_nxt;
   logic [7:0]       cause_nxt;

   logic [16:0]      lastAddr;
   logic [15:0]      lastRef;
   logic [5:0]       firstIdx;
   logic [4:0]       bitCnt;
   logic [31:0]      ctlMaskNow;
   logic [31:0]      ctlMaskQry;
   logic [31:0]      stsMaskQry;
   logic [COIL_W-1:0] coilVec;
   logic [DIN_W-1:0]  dinVec;
   logic [COIL_W-1:0] wrMask;
   logic [COIL_W-1:0] wrVals;
   logic [COIL_W-1:0] coilNew;
   logic [15:0]      coilRdBits;
   logic [15:0]      dinRdBits;
   logic [15:0]      logWord;
   logic             isWrite;
   logic             isRead;
   logic             doExec;

   function automatic logic [31:0] ctlMask(input logic alt);
      return alt ? CTL_MASK_ALT : CTL_MASK_NAT;
   endfunction

   function automatic logic [31:0] stsMask(input logic alt);
      return alt ? STS_MASK_ALT : STS_MASK_NAT;
   endfunction

   function automatic logic isSingle(input logic [7:0] fc);
      return (fc == FC_WR_COIL) || (fc == FC_WR_HOLD);
   endfunction

   assign qryReady  = qryReady_r;
   assign rspValid  = rspValid_r;
   assign rspExc    = rspExc_r;
   assign rspCode   = rspCode_r;
   assign rspData   = rspData_r;
   assign ctrlWord  = ctrlWord_r;
   assign relayCtrl = relayCtrl_r;

   assign ctlMaskNow = ctlMask(altProfile);
   assign ctlMaskQry = ctlMask(prof_r);
   assign stsMaskQry = stsMask(prof_r);

   assign lastAddr = {1'b0, addr_r} + {1'b0, qty_r} - 17'h00001;
   assign lastRef  = lastAddr[15:0];
   assign firstIdx = addr_r[5:0] - 6'h01;
   assign bitCnt   = qty_r[4:0];

   assign coilVec = {relayCtrl_r, ctrlWord_r & ctlMaskQry};

   assign dinVec = {diDelayed, statusWord & stsMaskQry};

   assign isWrite = (func_r == FC_WR_COIL) || (func_r == FC_WR_COILS) ||
                    (func_r == FC_WR_HOLD) || (func_r == FC_WR_HOLDS);
   assign isRead  = !isWrite;
   assign doExec  = (state_r == ST_EXEC) && (exc_r == EXC_NONE);

   mbsrv_bit_pick #(
      .W (COIL_W)
   ) u_coil_pick (
      .vec   (coilVec),
      .first (firstIdx),
      .cnt   (bitCnt),
      .bits  (coilRdBits)
   );

   mbsrv_bit_pick #(
      .W (DIN_W)
   ) u_din_pick (
      .vec   (dinVec),
      .first (firstIdx),
      .cnt   (bitCnt),
      .bits  (dinRdBits)
   );

   mbsrv_err_log u_log (
      .sys_clk   (sys_clk),
      .rst_n     (rst_n),
      .clrAll    (doExec && isWrite && addr_r == HR_CLEAR_ADDR &&
                  (func_r == FC_WR_HOLD || func_r == FC_WR_HOLDS) &&
                  wrWord_r == 16'h0001),
      .failEn    ((state_r == ST_EXEC) && (exc_r != EXC_NONE)),
      .failFunc  (func_r),
      .failCause (cause_r),
      .failRef   (addr_r),
      .okEn      (doExec),
      .wrEn      (doExec && isWrite),
      .wrRef     (lastRef),
      .rdEn      (doExec && isRead),
      .rdRef     (lastRef),
      .rdSel     (3'(addr_r - HR_FIRST)),
      .rdWord    (logWord)
   );

   // Query checks, in the order function, quantity, address, execution
   always_comb begin
      exc_nxt   = EXC_NONE;
      cause_nxt = CAUSE_NONE;
      unique case (func_r)
         FC_RD_COILS, FC_WR_COIL, FC_WR_COILS: begin
            if (qty_r == 16'h0000 || qty_r > MAX_BIT_QTY) begin
               exc_nxt = EXC_ILL_QTY;
            end else if (addr_r < COIL_FIRST || lastAddr > {1'b0, COIL_LAST}) begin
               exc_nxt = EXC_ILL_ADDR;
            end else if (func_r == FC_WR_COIL && wrWord_r != COIL_ON_VAL &&
                         wrWord_r != COIL_OFF_VAL) begin
               exc_nxt   = EXC_DEV_FAIL;
               cause_nxt = CAUSE_TYPE;
            end
         end
         FC_RD_INPUTS: begin
            if (qty_r == 16'h0000 || qty_r > MAX_BIT_QTY) begin
               exc_nxt = EXC_ILL_QTY;
            end else if (addr_r < COIL_FIRST || lastAddr > {1'b0, INPUT_LAST}) begin
               exc_nxt = EXC_ILL_ADDR;
            end
         end
         FC_RD_HOLD, FC_WR_HOLD, FC_WR_HOLDS: begin
            if (qty_r == 16'h0000 || qty_r > MAX_REG_QTY) begin
               exc_nxt = EXC_ILL_QTY;
            end else if (addr_r < HR_FIRST || addr_r > HR_GROUP_LAST) begin
               exc_nxt = EXC_ILL_ADDR;
            end else if (addr_r > HR_IMPL_LAST) begin
               exc_nxt   = EXC_DEV_FAIL;
               cause_nxt = CAUSE_INDEX;
            end else if (isWrite && addr_r != HR_CLEAR_ADDR) begin
               exc_nxt   = EXC_DEV_FAIL;
               cause_nxt = CAUSE_GENERAL;
            end else if (isWrite && wrWord_r > 16'h0001) begin
               exc_nxt   = EXC_DEV_FAIL;
               cause_nxt = CAUSE_LIMIT;
            end
         end
         default: begin
            exc_nxt = EXC_ILL_FUNC;
         end
      endcase
   end

   // Coil write merge; relay bits always pass, control bits restricted to those the profile defines
   always_comb begin
      wrMask = COIL_W'(({16'hFFFF, 16'hFFFF} >> (6'd32 - {1'b0, bitCnt}))) << firstIdx;
      wrVals = COIL_W'(wrBits_r) << firstIdx;
      wrMask = wrMask & {{RELAY_BITS{1'b1}}, ctlMaskQry};
      coilNew = (coilVec & ~wrMask) | (wrVals & wrMask);
   end

   always_comb begin
      state_nxt = state_r;
      unique case (state_r)
         ST_IDLE:  if (qryValid && qryReady_r) state_nxt = ST_CHECK;
         ST_CHECK: state_nxt = ST_EXEC;
         ST_EXEC:  state_nxt = ST_RESP;
         ST_RESP:  state_nxt = ST_IDLE;
      endcase
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_r    <= ST_IDLE;
         qryReady_r <= 1'b0;
      end else begin
         state_r    <= state_nxt;
         qryReady_r <= (state_nxt == ST_IDLE) && !(qryValid && qryReady_r);
      end
   end

   // Query capture; single writes carry an implied quantity of one
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         func_r   <= 8'h00;
         addr_r   <= 16'h0000;
         qty_r    <= 16'h0000;
         wrBits_r <= 16'h0000;
         wrWord_r <= 16'h0000;
         prof_r   <= 1'b0;
      end else if (state_r == ST_IDLE && qryValid && qryReady_r) begin
         func_r   <= qryFunc;
         addr_r   <= qryAddr;
         qty_r    <= isSingle(qryFunc) ? 16'h0001 : qryQty;
         wrBits_r <= (qryFunc == FC_WR_COIL) ? {15'h0000, qryWrWord == COIL_ON_VAL} : qryWrBits;
         wrWord_r <= qryWrWord;
         // Profile held per query so a change mid-query cannot split it
         prof_r   <= altProfile;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         exc_r   <= EXC_NONE;
         cause_r <= CAUSE_NONE;
      end else if (state_r == ST_CHECK) begin
         exc_r   <= exc_nxt;
         cause_r <= cause_nxt;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrlWord_r  <= 32'h00000000;
         relayCtrl_r <= 5'h00;
      end else if (doExec && (func_r == FC_WR_COIL || func_r == FC_WR_COILS)) begin
         ctrlWord_r  <= coilNew[CTL_BITS-1:0];
         relayCtrl_r <= coilNew[COIL_W-1:CTL_BITS];
      end else begin
         // Bits undefined in the live profile are forced low
         ctrlWord_r <= ctrlWord_r & ctlMaskNow;
      end
   end

   // Answer: exception code or read data, one-cycle pulse
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         rspValid_r <= 1'b0;
         rspExc_r   <= 1'b0;
         rspCode_r  <= EXC_NONE;
         rspData_r  <= 16'h0000;
      end else if (state_r == ST_EXEC) begin
         rspValid_r <= 1'b1;
         rspExc_r   <= (exc_r != EXC_NONE);
         rspCode_r  <= exc_r;
         if (exc_r != EXC_NONE || isWrite) begin
            rspData_r <= 16'h0000;
         end else begin
            unique case (func_r)
               FC_RD_COILS:  rspData_r <= coilRdBits;
               FC_RD_INPUTS: rspData_r <= dinRdBits;
               default:      rspData_r <= logWord;
            endcase
         end
      end else begin
         rspValid_r <= 1'b0;
      end
   end
endmodule

// [hdl/mbsrv_pkg.sv]
// Constants and types for the Modbus server object map and error log
//
// Operation
// - Unsupported function code answers exception 01h
// - Unsupported data address answers exception 02h
// - Excess register quantity answers exception 03h
// - Out-of-range written values never give 03h
// - Unrecoverable execution error answers exception 04h
// - Coils are readable and writable single bits
// - Coils carry the drive control word bits
// - References are 1-based wire addresses
// - Coils 1-32 carry profile command bits
// - Coils 33-37 drive relay outputs one-five
// - Discrete inputs are read-only single bits
// - Discrete inputs carry drive status word bits
// - Inputs 1-32 carry profile status bits
// - Inputs 33-38 return delayed digital inputs
// - Holding registers log the last query outcome
// - Successful query clears the cause register
// - Writing 1 to clear register empties log, except the written reference, which records the clear write
// - Failed query function code is logged
// - Exception 04h loads a defined cause code
// - Last failed object reference is logged
// - Last successfully written reference is logged
// - Last successfully read reference is logged
package mbsrv_pkg;
   localparam logic [7:0]  FC_RD_COILS    = 8'h01;
   localparam logic [7:0]  FC_RD_INPUTS   = 8'h02;
   localparam logic [7:0]  FC_RD_HOLD     = 8'h03;
   localparam logic [7:0]  FC_WR_COIL     = 8'h05;
   localparam logic [7:0]  FC_WR_HOLD     = 8'h06;
   localparam logic [7:0]  FC_WR_COILS    = 8'h0F;
   localparam logic [7:0]  FC_WR_HOLDS    = 8'h10;
   localparam logic [7:0]  EXC_NONE       = 8'h00;
   localparam logic [7:0]  EXC_ILL_FUNC   = 8'h01;
   localparam logic [7:0]  EXC_ILL_ADDR   = 8'h02;
   localparam logic [7:0]  EXC_ILL_QTY    = 8'h03;
   localparam logic [7:0]  EXC_DEV_FAIL   = 8'h04;
   localparam logic [7:0]  CAUSE_NONE     = 8'h00;
   localparam logic [7:0]  CAUSE_LIMIT    = 8'h02;
   localparam logic [7:0]  CAUSE_INDEX    = 8'h03;
   localparam logic [7:0]  CAUSE_TYPE     = 8'h05;
   localparam logic [7:0]  CAUSE_GENERAL  = 8'h65;
   localparam logic [15:0] COIL_ON_VAL    = 16'hFF00;
   localparam logic [15:0] COIL_OFF_VAL   = 16'h0000;
   localparam logic [15:0] COIL_FIRST     = 16'h0001;
   localparam logic [15:0] COIL_LAST      = 16'h0025;
   localparam logic [15:0] INPUT_LAST     = 16'h0026;
   localparam logic [15:0] HR_FIRST       = 16'h005A;
   localparam logic [15:0] HR_IMPL_LAST   = 16'h005F;
   localparam logic [15:0] HR_GROUP_LAST  = 16'h0064;
   localparam logic [15:0] HR_CLEAR_ADDR  = 16'h005A;
   localparam logic [15:0] MAX_BIT_QTY    = 16'h0010;
   localparam logic [15:0] MAX_REG_QTY    = 16'h0001;
   localparam logic [31:0] CTL_MASK_NAT   = 32'h0000FCFF;
   localparam logic [31:0] CTL_MASK_ALT   = 32'h03C33BF3;
   localparam logic [31:0] STS_MASK_NAT   = 32'h00007FFF;
   localparam logic [31:0] STS_MASK_ALT   = 32'h07D1F39B;
   localparam int          CTL_BITS       = 32;
   localparam int          RELAY_BITS     = 5;
   localparam int          DI_BITS        = 6;
   localparam int          CW_RAMP_STOP_INTERLOCK  = 0;
   localparam int          CW_COAST_STOP_INTERLOCK = 1;
   localparam int          CW_QUICK_STOP_INTERLOCK = 2;
   localparam int          CW_EXTERNAL_LOCATION_SELECT = 11;
   localparam int          SW_FAULT_TRIP_FLAG      = 3;
   localparam int          SW_SWITCH_ON_BLOCKED    = 6;
   localparam logic [2:0]  LOG_CLEAR      = 3'h0;
   localparam logic [2:0]  LOG_FUNC       = 3'h1;
   localparam logic [2:0]  LOG_CAUSE      = 3'h2;
   localparam logic [2:0]  LOG_FAIL_REF   = 3'h3;
   localparam logic [2:0]  LOG_WR_REF     = 3'h4;
   localparam logic [2:0]  LOG_RD_REF     = 3'h5;

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_CHECK,
      ST_EXEC,
      ST_RESP
   } mbsrv_state_t;
endpackage

// [hdl/mbsrv_bit_pick.sv]
// Packs a window of object bits into a response word, first bit lowest
`timescale 1ns/100ps
module mbsrv_bit_pick
   import mbsrv_pkg::*;
#(
   parameter int W = 38
) (
   input  wire logic [W-1:0] vec,
   input  wire logic [5:0]   first,
   input  wire logic [4:0]   cnt,
   output logic      [15:0]  bits
);
   logic [W-1:0] shifted;

   if (W < 16 || W > 63) begin : g_chk
      $error("mbsrv_bit_pick: W out of range");
   end

   assign shifted = vec >> first;

   for (genvar i = 0; i < 16; i++) begin : g_bit
      // Bits past the quantity read as zero
      assign bits[i] = (5'(i) < cnt) ? shifted[i] : 1'b0;
   end
endmodule

// [hdl/mbsrv_err_log.sv]
// Holding registers that record the outcome of the last query
`timescale 1ns/100ps
module mbsrv_err_log
   import mbsrv_pkg::*;
(
   input  wire logic        sys_clk,
   input  wire logic        rst_n,
   input  wire logic        clrAll,
   input  wire logic        failEn,
   input  wire logic [7:0]  failFunc,
   input  wire logic [7:0]  failCause,
   input  wire logic [15:0] failRef,
   input  wire logic        okEn,
   input  wire logic        wrEn,
   input  wire logic [15:0] wrRef,
   input  wire logic        rdEn,
   input  wire logic [15:0] rdRef,
   input  wire logic [2:0]  rdSel,
   output logic      [15:0] rdWord
);
   logic [7:0]  funcCode_r;
   logic [7:0]  causeCode_r;
   logic [15:0] failRef_r;
   logic [15:0] lastWr_r;
   logic [15:0] lastRd_r;

   // Later assignments win, so a record in the clearing cycle survives
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         funcCode_r  <= 8'h00;
         causeCode_r <= CAUSE_NONE;
         failRef_r   <= 16'h0000;
      end else begin
         if (clrAll) begin
            funcCode_r  <= 8'h00;
            causeCode_r <= CAUSE_NONE;
            failRef_r   <= 16'h0000;
         end
         if (okEn) begin
            causeCode_r <= CAUSE_NONE;
         end
         if (failEn) begin
            funcCode_r  <= failFunc;
            causeCode_r <= failCause;
            failRef_r   <= failRef;
         end
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         lastWr_r <= 16'h0000;
         lastRd_r <= 16'h0000;
      end else begin
         if (clrAll) begin
            lastWr_r <= 16'h0000;
            lastRd_r <= 16'h0000;
         end
         if (wrEn) begin
            lastWr_r <= wrRef;
         end
         if (rdEn) begin
            lastRd_r <= rdRef;
         end
      end
   end

   always_comb begin
      unique case (rdSel)
         LOG_FUNC:     rdWord = {8'h00, funcCode_r};
         LOG_CAUSE:    rdWord = {8'h00, causeCode_r};
         LOG_FAIL_REF: rdWord = failRef_r;
         LOG_WR_REF:   rdWord = lastWr_r;
         LOG_RD_REF:   rdWord = lastRd_r;
         default:      rdWord = 16'h0000;
      endcase
   end
endmodule

// [sim/mbsrv_top_properties.sv]
// Port-level properties of the Modbus server top
`timescale 1ns/100ps
module mbsrv_top_properties
   import mbsrv_pkg::*;
(
   input wire logic        sys_clk,
   input wire logic        rst_n,
   input wire logic        altProfile,
   input wire logic        qryValid,
   input wire logic [7:0]  qryFunc,
   input wire logic [15:0] qryAddr,
   input wire logic [15:0] qryQty,
   input wire logic [15:0] qryWrBits,
   input wire logic [15:0] qryWrWord,
   input wire logic [31:0] statusWord,
   input wire logic [5:0]  diDelayed,
   input wire logic        qryReady,
   input wire logic        rspValid,
   input wire logic        rspExc,
   input wire logic [7:0]  rspCode,
   input wire logic [15:0] rspData,
   input wire logic [31:0] ctrlWord,
   input wire logic [4:0]  relayCtrl
);
   logic        take;
   logic        known;
   logic        bitFc;
   logic [31:0] liveMask;
   assign take     = qryValid && qryReady;
   assign known    = qryFunc inside {FC_RD_COILS, FC_RD_INPUTS, FC_RD_HOLD, FC_WR_COIL, FC_WR_HOLD, FC_WR_COILS, FC_WR_HOLDS};
   assign bitFc    = qryFunc inside {FC_RD_COILS, FC_RD_INPUTS, FC_WR_COILS};
   assign liveMask = altProfile ? CTL_MASK_ALT : CTL_MASK_NAT;
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   property p_answer; take |=> !rspValid [*2] ##1 rspValid; endproperty
   a_answer: assert property (p_answer) else $error("answer not on third edge after take");
   property p_busy; take |=> !qryReady [*3] ##1 qryReady; endproperty
   a_busy: assert property (p_busy) else $error("ready wrong around a query");
   property p_exc_flag; rspValid |-> (rspExc == (rspCode != EXC_NONE)) && (!rspExc || rspData == 16'h0000); endproperty
   a_exc_flag: assert property (p_exc_flag) else $error("exception flag, code or data inconsistent");
   property p_ill_func; take && !known |-> ##3 rspValid && rspExc && rspCode == EXC_ILL_FUNC; endproperty
   a_ill_func: assert property (p_ill_func) else $error("unknown function not answered 01h");
   property p_ill_qty; take && bitFc && (qryQty == 16'h0000 || qryQty > MAX_BIT_QTY) |-> ##3 rspCode == EXC_ILL_QTY;
   endproperty
   a_ill_qty: assert property (p_ill_qty) else $error("bad bit quantity not answered 03h");
   property p_ill_addr; take && qryFunc == FC_RD_INPUTS && qryQty == 16'h0001 && (qryAddr == 16'h0000 ||
      qryAddr > INPUT_LAST) |-> ##3 rspCode == EXC_ILL_ADDR; endproperty
   a_ill_addr: assert property (p_ill_addr) else $error("bad input address not answered 02h");
   property p_range; take && qryFunc == FC_WR_HOLD && qryAddr == HR_CLEAR_ADDR && qryWrWord > 16'h0001
      |-> ##3 rspCode == EXC_DEV_FAIL; endproperty
   a_range: assert property (p_range) else $error("out-of-range value not answered 04h");
   property p_mask; $stable(altProfile) |-> (ctrlWord & ~liveMask) == 32'h0000_0000; endproperty
   a_mask: assert property (p_mask) else $error("control bit set outside profile");
   property p_read_quiet; take && qryFunc == FC_RD_INPUTS |-> ##2 ($stable(ctrlWord) && $stable(relayCtrl)) [*3];
   endproperty
   a_read_quiet: assert property (p_read_quiet) else $error("input read moved control outputs");
   c_wr_coils: cover property (take && qryFunc == FC_WR_COILS);
   c_dev_fail: cover property (rspValid && rspCode == EXC_DEV_FAIL);
   c_good_read: cover property (rspValid && !rspExc && rspData != 16'h0000);
endmodule
bind mbsrv_top mbsrv_top_properties i_props (
   .sys_clk, .rst_n, .altProfile, .qryValid, .qryFunc, .qryAddr, .qryQty, .qryWrBits, .qryWrWord,
   .statusWord, .diDelayed, .qryReady, .rspValid, .rspExc, .rspCode, .rspData, .ctrlWord, .relayCtrl
);

// [sim/mbsrv_client_model.sv]
// Modbus client model that issues one query at a time
`timescale 1ns/100ps
module mbsrv_client_model (
   input  wire logic        sys_clk,
   input  wire logic        qryReady,
   input  wire logic        rspValid,
   input  wire logic        rspExc,
   input  wire logic [7:0]  rspCode,
   input  wire logic [15:0] rspData,
   output logic             qryValid,
   output logic      [7:0]  qryFunc,
   output logic      [15:0] qryAddr,
   output logic      [15:0] qryQty,
   output logic      [15:0] qryWrBits,
   output logic      [15:0] qryWrWord
);
   initial begin
      {qryValid, qryFunc, qryAddr, qryQty, qryWrBits, qryWrWord} = '0;
   end
   task automatic query(input logic [7:0] f, input logic [15:0] a, q, wb, ww,
                        output logic exc, output logic [7:0] code, output logic [15:0] data, output bit ok);
      int n;
      ok = 1'b0;
      @(negedge sys_clk);
      {qryValid, qryFunc, qryAddr, qryQty, qryWrBits, qryWrWord} = {1'b1, f, a, q, wb, ww};
      for (n = 0; n < 16 && !ok; n++) begin
         @(posedge sys_clk);
         ok = qryReady;
      end
      @(negedge sys_clk);
      // Inverted once released, so a late sample is caught
      {qryValid, qryFunc, qryAddr, qryQty, qryWrBits, qryWrWord} = {1'b0, ~f, ~a, ~q, ~wb, ~ww};
      for (n = 0; n < 8 && ok && !rspValid; n++) begin
         @(negedge sys_clk);
      end
      ok = ok && rspValid;
      {exc, code, data} = {rspExc, rspCode, rspData};
   endtask
endmodule

// [sim/modbus_server_bitmap_and_errors_tb.sv]
// Self-checking bench for the Modbus server bit map and error log
`timescale 1ns/100ps
module modbus_server_bitmap_and_errors_tb
   import mbsrv_pkg::*;
;
   logic        sys_clk = 1'b0;
   logic        rst_n = 1'b0;
   logic        altProfile = 1'b0;
   logic [31:0] statusWord = 32'h0000_0000;
   logic [5:0]  diDelayed = 6'h00;
   logic        qryValid, qryReady, rspValid, rspExc, rExc;
   logic [7:0]  qryFunc, rspCode, rCode;
   logic [15:0] qryAddr, qryQty, qryWrBits, qryWrWord, rspData, rData, a, q, wb, lastWr, lastRd;
   logic [31:0] ctrlWord;
   logic [4:0]  relayCtrl;
   logic [36:0] coils = '0;
   int          miscompares = 0;
   int          checked = 0;
   int          seed = 13;
   int          op;
   // Function, address, quantity, value, exception, cause
   logic [71:0] excTab [17] = '{72'h08_0001_0001_0000_01_00, 72'h16_0001_0001_0000_01_00, 72'h2B_0001_0001_0000_01_00,
      72'h01_0001_0000_0000_03_00, 72'h0F_0001_0011_0000_03_00, 72'h03_005A_0002_0000_03_00,
      72'h02_0000_0011_0000_03_00, 72'h01_0000_0001_0000_02_00, 72'h01_0025_0002_0000_02_00,
      72'h02_0027_0001_0000_02_00, 72'h03_0059_0001_0000_02_00, 72'h06_0065_0001_0000_02_00,
      72'h03_0060_0001_0000_04_03, 72'h03_0064_0001_0000_04_03, 72'h06_005B_0001_0001_04_65,
      72'h06_005A_0001_0002_04_02, 72'h05_0005_0001_1234_04_05};

   always #10 sys_clk = ~sys_clk;

   mbsrv_top i_dut (.sys_clk, .rst_n, .altProfile, .qryValid, .qryFunc, .qryAddr, .qryQty, .qryWrBits,
      .qryWrWord, .statusWord, .diDelayed, .qryReady, .rspValid, .rspExc, .rspCode, .rspData, .ctrlWord, .relayCtrl);
   mbsrv_client_model i_client (.sys_clk, .qryReady, .rspValid, .rspExc, .rspCode, .rspData, .qryValid, .qryFunc,
      .qryAddr, .qryQty, .qryWrBits, .qryWrWord);

   function automatic logic [31:0] ctlMask(input logic alt);
      return alt ? CTL_MASK_ALT : CTL_MASK_NAT;
   endfunction
   function automatic logic [15:0] pick(input logic [37:0] v, input logic [15:0] a, q);
      logic [37:0] s;
      logic [16:0] m;
      s = v >> (a - 16'h0001);
      m = (17'h00001 << q) - 17'h00001;
      return s[15:0] & m[15:0];
   endfunction
   task automatic check(input string name, input logic [31:0] seen, exp);
      checked++;
      if (seen !== exp) begin
         miscompares++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic report_and_stop;
      $display("comparisons %0d mismatches %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   task automatic qry(input logic [7:0] f, input logic [15:0] a, q, wb, ww);
      bit ok;
      i_client.query(f, a, q, wb, ww, rExc, rCode, rData, ok);
      if (!ok) begin
         miscompares++;
         report_and_stop();
      end
   endtask
   task automatic expOk(input logic [15:0] exp);
      check("exception flag", 32'(rExc), 32'h0000_0000);
      check("response code", 32'(rCode), 32'(EXC_NONE));
      check("read data", 32'(rData), 32'(exp));
   endtask
   task automatic rdLog(input logic [2:0] idx, input logic [15:0] exp);
      qry(FC_RD_HOLD, HR_FIRST + 16'(idx), 16'h0001, 16'h0000, 16'h0000);
      check("log register", 32'(rData), 32'(exp));
      lastRd = HR_FIRST + 16'(idx);
   endtask
   task automatic expExc(input logic [71:0] e);
      qry(e[71:64], e[63:48], e[47:32], 16'h0000, e[31:16]);
      check("exception flag", 32'(rExc), 32'h0000_0001);
      check("exception code", 32'(rCode), 32'(e[15:8]));
      check("read data", 32'(rData), 32'h0000_0000);
      rdLog(LOG_CAUSE, 16'(e[7:0]));
      rdLog(LOG_FUNC, 16'(e[71:64]));
      rdLog(LOG_FAIL_REF, e[63:48]);
   endtask
   task automatic wrCoils(input logic [7:0] f, input logic [15:0] a, q, wb, ww);
      logic [31:0] m;
      m = ctlMask(altProfile);
      qry(f, a, q, wb, ww);
      expOk(16'h0000);
      // Undefined control coils are dropped
      for (int k = 0; k < 32'(q); k++) begin
         if (a + 16'(k) > 16'h0020 || m[a - 16'h0001 + 16'(k)]) coils[a - 16'h0001 + 16'(k)] = wb[k];
      end
      lastWr = a + q - 16'h0001;
      check("control word", ctrlWord, coils[31:0] & m);
      check("relay control", 32'(relayCtrl), 32'(coils[36:32]));
   endtask
   task automatic rdBits(input logic [7:0] f, input logic [15:0] a, q);
      logic [37:0] v;
      v = {diDelayed, statusWord & (altProfile ? STS_MASK_ALT : STS_MASK_NAT)};
      if (f == FC_RD_COILS) v = {1'b0, coils[36:32], coils[31:0] & ctlMask(altProfile)};
      qry(f, a, q, 16'h0000, 16'h0000);
      expOk(pick(v, a, q));
      lastRd = a + q - 16'h0001;
   endtask

   initial begin
      repeat (20) @(negedge sys_clk);
      check("control word in reset", ctrlWord, 32'h0000_0000);
      rst_n = 1'b1;
      foreach (excTab[i]) begin
         expExc(excTab[i]);
      end
      qry(FC_RD_COILS, COIL_FIRST, 16'h0001, 16'h0000, 16'h0000);
      expOk(16'h0000);
      rdLog(LOG_CAUSE, 16'(CAUSE_NONE));
      qry(FC_WR_HOLD, HR_CLEAR_ADDR, 16'h0001, 16'h0000, 16'h0000);
      rdLog(LOG_FUNC, 16'(FC_WR_COIL));
      qry(FC_WR_HOLD, HR_CLEAR_ADDR, 16'h0001, 16'h0000, 16'h0001);
      rdLog(LOG_FUNC, 16'h0000);
      rdLog(LOG_FAIL_REF, 16'h0000);
      rdLog(LOG_WR_REF, HR_CLEAR_ADDR);
      rdLog(LOG_RD_REF, 16'h005E);
      rdLog(LOG_CLEAR, 16'h0000);
      lastWr = HR_CLEAR_ADDR;
      wrCoils(FC_WR_COILS, 16'h0021, 16'h0005, 16'h0015, 16'h0000);
      rdBits(FC_RD_INPUTS, 16'h0021, 16'h0006);
      // Write last, so a profile change never follows an input read directly
      wrCoils(FC_WR_COILS, COIL_FIRST, 16'h0010, 16'hFFFF, 16'h0000);
      for (int i = 0; i < 60; i++) begin
         altProfile = 1'($random(seed));
         coils[31:0] = coils[31:0] & ctlMask(altProfile);
         statusWord = $random(seed);
         diDelayed = 6'($random(seed));
         op = $unsigned($random(seed)) % 4;
         q = (op == 1) ? 16'h0001 : 16'h0001 + 16'($unsigned($random(seed)) % 16);
         a = 16'h0001 + 16'($unsigned($random(seed)) % ((op == 3 ? 39 : 38) - 32'(q)));
         wb = 16'($random(seed));
         case (op)
            0: wrCoils(FC_WR_COILS, a, q, wb, 16'h0000);
            1: wrCoils(FC_WR_COIL, a, q, {15'h0000, wb[0]}, wb[0] ? COIL_ON_VAL : COIL_OFF_VAL);
            2: rdBits(FC_RD_COILS, a, q);
            default: rdBits(FC_RD_INPUTS, a, q);
         endcase
         rdLog(LOG_RD_REF, lastRd);
         rdLog(LOG_WR_REF, lastWr);
      end
      report_and_stop();
   end
endmodule
